// ==== hw/lpsc_map.svh ====
`ifndef LPSC_MAP_SVH
`define LPSC_MAP_SVH

// Data port selection values for the address port's select field.
`define LPSC_SEL_STATUS 3'h0
`define LPSC_SEL_PRIM 3'h1
// Address port field positions.
`define LPSC_RAP_SEL_HI 3
`define LPSC_RAP_SEL_LO 1

// Status register bit positions.
`define LPSC_B_STOP 14
`define LPSC_B_TXON 11
`define LPSC_B_RXON 10
`define LPSC_B_IEN 9
`define LPSC_B_SUM 8
`define LPSC_B_BUS_TIMEOUT_ERROR 7
`define LPSC_B_FLAG_LO 1

// Primitive exchange register bit positions.
`define LPSC_B_HOST_CMD_ERROR 15
`define LPSC_B_UAV 14
`define LPSC_B_HOST_CMD_PARAM_HI 13
`define LPSC_B_HOST_CMD_PARAM_LO 12
`define LPSC_B_HOST_CMD_CODE_HI 11
`define LPSC_B_HOST_CMD_CODE_LO 8
`define LPSC_B_INDICATION_LOST 7
`define LPSC_B_PAV 6
`define LPSC_B_INDICATION_CAUSE_HI 5
`define LPSC_B_INDICATION_CAUSE_LO 4
`define LPSC_B_INDICATION_CODE_HI 3
`define LPSC_B_INDICATION_CODE_LO 0

// Reset values.
`define LPSC_RST_FLAGS 7'h00
`define LPSC_RST_RDATA 16'h0000

// Bus master ready timeout in system clocks.
`define LPSC_READY_TIMEOUT 9'h100

`endif

// ==== hw/lpsc_pkg.sv ====
package lpsc_pkg;

  // Host command codes carried in the primitive exchange register.
  typedef enum logic [3:0] {
    CMD_STOP = 4'h0,
    CMD_START = 4'h1,
    CMD_INIT = 4'h2,
    CMD_TRANSP = 4'h3,
    CMD_STATUS = 4'h4,
    CMD_SELFTEST = 4'h5,
    CMD_CONN_REQ = 4'h6,
    CMD_CONN_RSP = 4'h7,
    CMD_RST_REQ = 4'h8,
    CMD_RST_RSP = 4'h9,
    CMD_XID_REQ = 4'hA,
    CMD_XID_RSP = 4'hB,
    CMD_TEST_REQ = 4'hC,
    CMD_TEST_RSP = 4'hD,
    CMD_DISC_REQ = 4'hE,
    CMD_UNUSED = 4'hF
  } lpsc_cmd_t;

  // Link phase kept by the block.
  typedef enum logic [1:0] {PH_STOPPED, PH_DISC, PH_INFO, PH_TRANSP} lpsc_phase_t;

  // Command interpreter states.
  typedef enum logic {ST_IDLE, ST_EXEC} lpsc_state_t;

  // Action strobes handed to the protocol engine, one cycle each.
  typedef struct packed {
    logic forward;
    lpsc_cmd_t code;
    logic [1:0] param;
    logic ring_reset;
    logic send_sabm;
    logic t1_start;
    logic t1_stop;
    logic send_dm;
    logic init_read;
    logic discard_unsent;
  } lpsc_act_t;

  // Provider indication posted by the protocol engine.
  typedef struct packed {
    logic post;
    logic [3:0] code;
    logic [1:0] cause;
  } lpsc_ind_t;

  // Hardware event strobes that set the interrupt cause flags.
  typedef struct packed {
    logic missed;
    logic rx_push;
    logic rx_fifo_full;
    logic tx_in_frame;
    logic tx_empty;
    logic txf_empty;
    logic tx_desc_done;
    logic rx_desc_done;
  } lpsc_evt_t;

endpackage : lpsc_pkg

// ==== hw/lpsc_top.sv ====
`timescale 1ns/1ps
`include "lpsc_map.svh"

module lpsc_top (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic BUS_SEL_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_ADR_I,
  input wire logic [15:0] BUS_WDATA_I,
  input wire logic DMA_ADDR_ON_I,
  input wire logic DMA_READY_I,
  input wire lpsc_pkg::lpsc_evt_t EVT_I,
  input wire lpsc_pkg::lpsc_ind_t IND_I,
  input wire logic LINK_UP_I,
  input wire logic LINK_DOWN_I,
  output logic [15:0] BUS_RDATA_O,
  output logic BUS_ACK_O,
  output logic IRQ_N_O,
  output logic STOPPED_O,
  output logic TX_ON_O,
  output logic RX_ON_O,
  output logic TX_ABORT_O,
  output lpsc_pkg::lpsc_act_t ACT_O,
  output lpsc_pkg::lpsc_phase_t PHASE_O
);
  import lpsc_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [2:0] sel_r; // Data port register select.
  logic [7:1] flag_r; // Cause flags: 7 timeout, 6 missed, 5 overrun, 4 underrun,
                      // 3 primitive, 2 transmit done, 1 receive done.
  logic irq_enable_r; // Interrupt enable.
  logic host_cmd_error_r; // Command conflicted with the link state.
  logic host_cmd_valid_r; // Host has a command pending.
  logic [1:0] host_cmd_param_r; // Command parameter.
  logic [3:0] host_cmd_code_r; // Command code.
  logic indication_lost_r; // An indication was dropped.
  logic indication_valid_r; // An indication waits for the host.
  logic [1:0] indication_cause_r; // Cause code of the indication.
  logic [3:0] indication_code_r; // Indication code.
  logic [8:0] wait_cnt_r; // Clocks spent waiting for ready.
  logic init_done_r; // Initialization block has been read once.
  lpsc_phase_t phase_r; // Current link phase.
  lpsc_state_t state_r; // Interpreter state.
  logic cmd_ok; // Pending command is legal in the current phase.
  logic stop_now; // Stop command executing this cycle.
  logic timeout_hit; // Ready timeout reached this cycle.
  logic [7:1] flag_set; // Hardware set strobes.
  logic wr_stat; // Host write to the status register.
  logic wr_prim; // Host write to the primitive exchange register.
  lpsc_cmd_t cmd; // Pending command as an enum.

  // Set wins over a same-cycle write-one clear, so no event is lost.
  function automatic logic flag_nxt(input logic cur, input logic set, input logic clr);
    flag_nxt = set | (cur & ~clr);
  endfunction : flag_nxt

  assign cmd = lpsc_cmd_t'(host_cmd_code_r);
  assign wr_stat = BUS_SEL_I & BUS_WR_I & ~BUS_ADR_I & (sel_r == `LPSC_SEL_STATUS);
  assign wr_prim = BUS_SEL_I & BUS_WR_I & ~BUS_ADR_I & (sel_r == `LPSC_SEL_PRIM);
  assign stop_now = (state_r == ST_EXEC) & (cmd == CMD_STOP);
  assign timeout_hit = DMA_ADDR_ON_I & ~DMA_READY_I
                       & (wait_cnt_r == `LPSC_READY_TIMEOUT - 9'h001);

  // ****************************************************************
  // Command legality against the link phase
  // ****************************************************************
  // Each command is checked here; illegal ones only raise the error flag and cause flag 3.
  always_comb
  begin
    case (cmd)
      CMD_STOP: cmd_ok = 1'b1;
      CMD_START: cmd_ok = (phase_r == PH_STOPPED) | (phase_r == PH_TRANSP);
      CMD_INIT: cmd_ok = (phase_r == PH_STOPPED);
      CMD_TRANSP: cmd_ok = (phase_r != PH_TRANSP);
      CMD_STATUS: cmd_ok = init_done_r;
      CMD_SELFTEST: cmd_ok = (phase_r == PH_STOPPED);
      CMD_CONN_REQ, CMD_CONN_RSP: cmd_ok = (phase_r == PH_DISC);
      CMD_UNUSED: cmd_ok = 1'b0;
      default: cmd_ok = (phase_r != PH_STOPPED);
    endcase
  end

  // ****************************************************************
  // Hardware events
  // ****************************************************************
  always_comb
  begin
    flag_set[7] = timeout_hit;
    flag_set[6] = EVT_I.missed;
    flag_set[5] = EVT_I.rx_push & EVT_I.rx_fifo_full;
    flag_set[4] = EVT_I.tx_in_frame & EVT_I.tx_empty & EVT_I.txf_empty;
    flag_set[3] = IND_I.post | ((state_r == ST_EXEC) & ~cmd_ok);
    flag_set[2] = EVT_I.tx_desc_done;
    flag_set[1] = EVT_I.rx_desc_done;
  end

  // Counts clocks from address out to ready; restarts on every ready.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I || !DMA_ADDR_ON_I || DMA_READY_I || timeout_hit)
      wait_cnt_r <= 9'h000;
    else
      wait_cnt_r <= wait_cnt_r + 9'h001;
  end

  // ****************************************************************
  // Address port
  // ****************************************************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      sel_r <= 3'h0;
    else if (BUS_SEL_I && BUS_WR_I && BUS_ADR_I)
      sel_r <= BUS_WDATA_I[`LPSC_RAP_SEL_HI:`LPSC_RAP_SEL_LO];
  end

  // ****************************************************************
  // Interrupt cause flags and enable
  // ****************************************************************
  // Stop and bus reset clear everything; a set in that cycle is dropped
  // because stop means all activity is torn down anyway.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I || stop_now)
    begin
      flag_r <= `LPSC_RST_FLAGS;
      irq_enable_r <= 1'b0;
    end
    else
    begin
      for (int i = 1; i <= 7; i++)
        flag_r[i] <= flag_nxt(flag_r[i], flag_set[i], wr_stat & BUS_WDATA_I[i]);
      if (wr_stat)
        irq_enable_r <= BUS_WDATA_I[`LPSC_B_IEN];
    end
  end

  // Pin is low while any cause is set and interrupts are enabled.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      IRQ_N_O <= 1'b1;
    else
      IRQ_N_O <= ~((|flag_r) & irq_enable_r);
  end

  // ****************************************************************
  // Host command half of the primitive exchange register
  // ****************************************************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      host_cmd_error_r <= 1'b0;
      host_cmd_valid_r <= 1'b0;
      host_cmd_param_r <= 2'h0;
      host_cmd_code_r <= 4'h0;
    end
    else
    begin
      host_cmd_error_r <= flag_nxt(host_cmd_error_r, (state_r == ST_EXEC) & ~cmd_ok,
                                   wr_prim & BUS_WDATA_I[`LPSC_B_HOST_CMD_ERROR]);
      // Device clear after processing; the host may re-arm in the same cycle.
      if (wr_prim && BUS_WDATA_I[`LPSC_B_UAV])
        host_cmd_valid_r <= 1'b1;
      else if (state_r == ST_EXEC)
        host_cmd_valid_r <= 1'b0;
      // Code and parameter are frozen while a command is pending.
      if (wr_prim && !host_cmd_valid_r)
      begin
        host_cmd_param_r <= BUS_WDATA_I[`LPSC_B_HOST_CMD_PARAM_HI:`LPSC_B_HOST_CMD_PARAM_LO];
        host_cmd_code_r <= BUS_WDATA_I[`LPSC_B_HOST_CMD_CODE_HI:`LPSC_B_HOST_CMD_CODE_LO];
      end
    end
  end

  // ****************************************************************
  // Provider indication half of the primitive exchange register
  // ****************************************************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      indication_valid_r <= 1'b0;
      indication_lost_r <= 1'b0;
      indication_code_r <= 4'h0;
      indication_cause_r <= 2'h0;
    end
    else if (IND_I.post && indication_valid_r)
      indication_lost_r <= 1'b1;
    else if (IND_I.post)
    begin
      indication_valid_r <= 1'b1;
      indication_code_r <= IND_I.code;
      indication_cause_r <= IND_I.cause;
    end
    else if (wr_prim && BUS_WDATA_I[`LPSC_B_PAV])
    begin
      indication_valid_r <= 1'b0;
      indication_lost_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Command interpreter
  // ****************************************************************
  // One cycle of execution per command keeps the action strobes simple.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE: state_r <= host_cmd_valid_r ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Link phase follows commands and engine reports.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      phase_r <= PH_STOPPED;
      init_done_r <= 1'b0;
    end
    else if (state_r == ST_EXEC && cmd_ok)
    begin
      case (cmd)
        CMD_STOP: phase_r <= PH_STOPPED;
        CMD_START: phase_r <= (host_cmd_param_r == 2'h1) ? PH_INFO : PH_DISC;
        CMD_TRANSP: phase_r <= PH_TRANSP;
        CMD_INIT: init_done_r <= 1'b1;
        default: phase_r <= phase_r;
      endcase
    end
    else if (phase_r != PH_STOPPED && phase_r != PH_TRANSP)
    begin
      if (LINK_DOWN_I)
        phase_r <= PH_DISC;
      else if (LINK_UP_I)
        phase_r <= PH_INFO;
    end
  end

  // Action strobes for the protocol engine.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
      ACT_O <= '0;
    else
    begin
      ACT_O <= '0;
      if (state_r == ST_EXEC && cmd_ok)
      begin
        ACT_O.forward <= 1'b1;
        ACT_O.code <= cmd;
        ACT_O.param <= host_cmd_param_r;
        ACT_O.ring_reset <= (cmd == CMD_START);
        ACT_O.init_read <= (cmd == CMD_INIT);
        ACT_O.send_sabm <= (cmd == CMD_RST_REQ) & (phase_r == PH_INFO);
        ACT_O.t1_start <= (cmd == CMD_RST_REQ) & (phase_r != PH_INFO);
        ACT_O.t1_stop <= (cmd == CMD_RST_RSP) & (phase_r != PH_INFO);
        ACT_O.send_dm <= (cmd == CMD_DISC_REQ) & (phase_r == PH_DISC);
        ACT_O.discard_unsent <= (host_cmd_param_r == 2'h1) & ((cmd == CMD_CONN_REQ)
          | (cmd == CMD_CONN_RSP) | (cmd == CMD_RST_REQ) | (cmd == CMD_RST_RSP));
      end
    end
  end

  // ****************************************************************
  // Link enables and pin-level status
  // ****************************************************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I || stop_now || timeout_hit)
    begin
      TX_ON_O <= 1'b0;
      RX_ON_O <= 1'b0;
    end
    else if (state_r == ST_EXEC && cmd_ok && cmd == CMD_START)
    begin
      TX_ON_O <= 1'b1;
      RX_ON_O <= 1'b1;
    end
  end

  // Stopped drives the line to all ones and halts DMA outside.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      STOPPED_O <= 1'b1;
      PHASE_O <= PH_STOPPED;
      TX_ABORT_O <= 1'b0;
    end
    else
    begin
      STOPPED_O <= (phase_r == PH_STOPPED);
      PHASE_O <= phase_r;
      TX_ABORT_O <= flag_set[4];
    end
  end

  // ****************************************************************
  // Data port read and acknowledge
  // ****************************************************************
  // Unselected registers read as zero; the answer comes one clock later.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      BUS_RDATA_O <= `LPSC_RST_RDATA;
      BUS_ACK_O <= 1'b0;
    end
    else
    begin
      BUS_ACK_O <= BUS_SEL_I;
      BUS_RDATA_O <= 16'h0000;
      if (BUS_SEL_I && !BUS_WR_I)
      begin
        if (BUS_ADR_I)
          BUS_RDATA_O <= {12'h000, sel_r, 1'b0};
        else if (sel_r == `LPSC_SEL_STATUS)
          BUS_RDATA_O <= {1'b0, (phase_r == PH_STOPPED), 2'h0, TX_ON_O, RX_ON_O,
                          irq_enable_r, |flag_r, flag_r, 1'b0};
        else if (sel_r == `LPSC_SEL_PRIM)
          BUS_RDATA_O <= {host_cmd_error_r, host_cmd_valid_r, host_cmd_param_r,
                          host_cmd_code_r, indication_lost_r, indication_valid_r,
                          indication_cause_r, indication_code_r};
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence stall_s;
    DMA_ADDR_ON_I & ~DMA_READY_I;
  endsequence

  timeout_flag_a: assert property ((stall_s [*8]) ##0 (wait_cnt_r == 9'h0FF)
    |=> flag_r[7] & ~TX_ON_O & ~RX_ON_O) else $error("ready timeout not flagged");
  overrun_set_a: assert property (EVT_I.rx_push & EVT_I.rx_fifo_full & ~stop_now
    |=> flag_r[5]) else $error("overrun lost");
  underrun_abort_a: assert property (flag_set[4] & ~stop_now
    |=> TX_ABORT_O & flag_r[4]) else $error("underrun abort missing");
  irq_pin_a: assert property (##1 IRQ_N_O == ~($past(|flag_r) & $past(irq_enable_r)))
    else $error("interrupt pin wrong");
  set_wins_a: assert property (EVT_I.missed & wr_stat & BUS_WDATA_I[6] & ~stop_now
    |=> flag_r[6]) else $error("set lost to clear");
  stop_clear_a: assert property (stop_now |=> (flag_r == 7'h00) & ~irq_enable_r ##1
    STOPPED_O) else $error("stop did not clear");
  cmd_done_a: assert property (host_cmd_valid_r & state_r == ST_IDLE ##1
    ~(wr_prim & BUS_WDATA_I[14]) |=> ~host_cmd_valid_r) else $error("command not retired");
  cmd_error_a: assert property (state_r == ST_EXEC & ~cmd_ok
    |=> host_cmd_error_r & flag_r[3] & ~ACT_O.forward) else $error("conflict not flagged");
  lost_post_a: assert property (IND_I.post & indication_valid_r
    |=> indication_lost_r & indication_valid_r) else $error("lost not set");
  transp_hold_a: assert property (phase_r == PH_TRANSP & ~(state_r == ST_EXEC & cmd_ok)
    |=> phase_r == PH_TRANSP) else $error("left transparent phase");

endmodule : lpsc_top

// ==== sim/lpsc_top_bench.sv ====
`timescale 1ns/1ps

module lpsc_top_bench;
  import lpsc_pkg::*;

  // ************************************************************
  // Stimulus, reference model state and counters
  // ************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic wr_en = 1'b0;
  logic adr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic addr_on = 1'b0;
  logic ready = 1'b0;
  lpsc_evt_t evt = '0;
  lpsc_ind_t ind = '0;
  logic up = 1'b0;
  logic dn = 1'b0;
  logic [15:0] rdata;
  logic ack, irq_n, stopped, tx_on, rx_on, tx_abort;
  lpsc_act_t act;
  lpsc_phase_t phase;
  // Model: phase, flags 7..1, enable, and the primitive register fields.
  logic [1:0] ph, upar, cause;
  logic [7:1] fl;
  logic [3:0] ucod, icod;
  logic inited, ien, host_cmd_error, lost, indication_valid;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // Event inputs and the flag mask each one must raise; partial terms raise none.
  logic [7:0] ev_in [8] = '{8'h80, 8'h40, 8'h20, 8'h60, 8'h18, 8'h1C, 8'h02, 8'h01};
  logic [7:0] ev_fl [8] = '{8'h40, 8'h00, 8'h00, 8'h20, 8'h00, 8'h10, 8'h04, 8'h02};

  // The clock runs at 20 MHz.
  always #25 clk = ~clk;

  lpsc_top dut (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .BUS_SEL_I(sel), .BUS_WR_I(wr_en),
    .BUS_ADR_I(adr), .BUS_WDATA_I(wdata), .DMA_ADDR_ON_I(addr_on),
    .DMA_READY_I(ready), .EVT_I(evt), .IND_I(ind), .LINK_UP_I(up),
    .LINK_DOWN_I(dn), .BUS_RDATA_O(rdata), .BUS_ACK_O(ack), .IRQ_N_O(irq_n),
    .STOPPED_O(stopped), .TX_ON_O(tx_on), .RX_ON_O(rx_on),
    .TX_ABORT_O(tx_abort), .ACT_O(act), .PHASE_O(phase)
  );

  // Cuts a hang short; the sequence needs well under a quarter of this.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures++;
      results();
    end
  end

  // ************************************************************
  // Comparison and reporting
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_act(input lpsc_act_t got, input lpsc_act_t exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_act

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // ************************************************************
  // Bus cycles and stimulus tasks
  // ************************************************************
  // One access: strobe for one cycle, answer sampled one cycle later.
  task automatic bus(input logic a, input logic w, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk);
    sel = 1'b1;
    wr_en = w;
    adr = a;
    wdata = d;
    @(negedge clk);
    sel = 1'b0;
    q = rdata;
    chk({15'h0000, ack}, 16'h0001);
  endtask : bus

  // Selects a register through the address port, then writes it.
  // The model follows the write, so expectations never lag the design.
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, 1'b1, {12'h000, s, 1'b0}, q);
    bus(1'b0, 1'b1, d, q);
    if (s == 3'h1)
    begin
      host_cmd_error = host_cmd_error & ~d[15];
      indication_valid = indication_valid & ~d[6];
      lost = lost & indication_valid;
      upar = d[13:12];
      ucod = d[11:8];
    end
    else if (s == 3'h0)
    begin
      fl = fl & ~d[7:1];
      ien = d[9];
    end
  endtask : wr

  task automatic rd(input logic [2:0] s, output logic [15:0] q);
    bus(1'b1, 1'b1, {12'h000, s, 1'b0}, q);
    bus(1'b0, 1'b0, 16'h0000, q);
  endtask : rd

  // Reads both registers and the pin; link-enable bits are checked apart.
  task automatic chk_regs();
    logic [15:0] q;
    rd(3'h0, q);
    chk(q & 16'hF3FF, {1'b0, ph == 2'd0, 4'h0, ien, |fl, fl, 1'b0});
    rd(3'h1, q);
    chk(q, {host_cmd_error, 1'b0, upar, ucod, lost, indication_valid, cause, icod});
    chk({15'h0000, irq_n}, {15'h0000, ~(ien & |fl)});
  endtask : chk_regs

  // Pulses an event pattern for one cycle.
  task automatic pulse_evt(input logic [7:0] v, input logic [7:0] m);
    @(negedge clk);
    evt = lpsc_evt_t'(v);
    @(negedge clk);
    evt = '0;
    chk({15'h0000, tx_abort}, {15'h0000, m[4]});
    fl = fl | m[7:1];
  endtask : pulse_evt

  // Posts a provider indication; a post over a pending one is lost.
  task automatic post(input logic [3:0] c, input logic [1:0] k);
    @(negedge clk);
    ind = {1'b1, c, k};
    @(negedge clk);
    ind = '0;
    fl[3] = 1'b1;
    if (indication_valid)
      lost = 1'b1;
    else
    begin
      indication_valid = 1'b1;
      icod = c;
      cause = k;
    end
  endtask : post

  // Holds an address without ready for n cycles, then answers.
  task automatic stall(input int n);
    @(negedge clk);
    addr_on = 1'b1;
    ready = 1'b0;
    repeat (n) @(negedge clk);
    addr_on = 1'b0;
    ready = 1'b1;
    if (n >= 256)
      fl[7] = 1'b1;
  endtask : stall

  // One engine pulse; the phase moves only between disconnected and info.
  task automatic link(input logic u, input logic d);
    @(negedge clk);
    up = u;
    dn = d;
    @(negedge clk);
    up = 1'b0;
    dn = 1'b0;
    // The phase register moves on the pulse edge; the phase pins follow one clock later.
    @(negedge clk);
    if (ph == 2'd1 || ph == 2'd2)
      ph = d ? 2'd1 : (u ? 2'd2 : ph);
    chk({14'h0000, phase}, {14'h0000, ph});
  endtask : link

  function automatic logic legal(input logic [3:0] c);
    case (c)
      4'h0: return 1'b1;
      4'h1: return ph == 2'd0 || ph == 2'd3;
      4'h2, 4'h5: return ph == 2'd0;
      4'h3: return ph != 2'd3;
      4'h4: return inited;
      4'h6, 4'h7: return ph == 2'd1;
      4'hF: return 1'b0;
      default: return ph != 2'd0;
    endcase
  endfunction : legal

  // Issues a host command and checks the action strobe two edges later.
  task automatic cmd(input logic [3:0] c, input logic [1:0] p);
    logic ok;
    lpsc_act_t e;
    ok = legal(c);
    e = '0;
    wr(3'h1, {2'b01, p, c, 8'h00});
    if (ok)
    begin
      e.forward = 1'b1;
      e.code = lpsc_cmd_t'(c);
      e.param = p;
      e.ring_reset = c == 4'h1;
      e.send_sabm = c == 4'h8 && ph == 2'd2;
      e.t1_start = c == 4'h8 && ph != 2'd2;
      e.t1_stop = c == 4'h9 && ph != 2'd2;
      e.send_dm = c == 4'hE && ph == 2'd1;
      e.init_read = c == 4'h2;
      e.discard_unsent = p == 2'd1 && c >= 4'h6 && c <= 4'h9;
      inited = inited | (c == 4'h2);
      ph = c == 4'h0 ? 2'd0 : c == 4'h3 ? 2'd3 : c == 4'h1 ? (p[0] ? 2'd2 : 2'd1) : ph;
      fl = c == 4'h0 ? 7'h00 : fl;
      ien = ien & (c != 4'h0);
    end
    else
    begin
      host_cmd_error = 1'b1;
      fl[3] = 1'b1;
    end
    @(negedge clk);
    @(negedge clk);
    chk_act(act, e);
    // Stopped and phase pins are copied from the phase register one clock after it moves.
    @(negedge clk);
    chk({13'h0000, stopped, phase}, {13'h0000, ph == 2'd0, ph});
    if (ok && c == 4'h0)
      chk({14'h0000, tx_on, rx_on}, 16'h0000);
    else if (ok && c == 4'h1)
      chk({14'h0000, tx_on, rx_on}, 16'h0003);
    chk_regs();
    if (!ok)
    begin
      wr(3'h1, 16'h8000);
      wr(3'h0, {6'h00, ien, 9'h008});
    end
  endtask : cmd

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin : main_seq
    logic [15:0] q;
    logic [3:0] c;
    void'($urandom(32'h1f7fc574));
    {ph, upar, cause, fl, ucod, icod} = '0;
    {inited, ien, host_cmd_error, lost, indication_valid} = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk_regs();
    wr(3'h5, 16'hFFFF);
    rd(3'h5, q);
    chk(q, 16'h0000);
    for (int i = 0; i < 8; i++)
      pulse_evt(ev_in[i], ev_fl[i]);
    chk_regs();
    cmd(4'h2, 2'd0);
    cmd(4'h1, 2'd0);
    chk({14'h0000, tx_on, rx_on}, 16'h0003);
    stall(255);
    stall(255);
    chk_regs();
    stall(256);
    chk_regs();
    chk({14'h0000, tx_on, rx_on}, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      post(4'hF - 4'(k * 3), 2'(k));
      post(4'h5, 2'(3 - k));
      chk_regs();
      wr(3'h1, 16'h0040);
      chk_regs();
    end
    wr(3'h0, 16'h0200);
    chk_regs();
    for (int k = 1; k < 8; k++)
    begin
      wr(3'h0, 16'h0200 | (16'h0001 << k));
      chk_regs();
    end
    // Set and clear of one flag in the same cycle: the set must survive.
    bus(1'b1, 1'b1, 16'h0000, q);
    @(negedge clk);
    evt = lpsc_evt_t'(8'h80);
    sel = 1'b1;
    wr_en = 1'b1;
    adr = 1'b0;
    wdata = 16'h0240;
    @(negedge clk);
    evt = '0;
    sel = 1'b0;
    fl[6] = 1'b1;
    chk_regs();
    cmd(4'h0, 2'd0);
    // Every code in turn, starting in the stopped phase, then a random walk of codes and link pulses.
    for (int k = 0; k < 16; k++)
      cmd(4'(k), 2'd0);
    for (int k = 0; k < 150; k++)
    begin
      c = 4'($urandom % 16);
      if ($urandom % 4 == 0)
        link(1'($urandom), 1'($urandom));
      else if (c == 4'h1 || (c >= 4'h6 && c <= 4'h9))
        cmd(c, 2'($urandom % 2));
      else
        cmd(c, 2'd0);
    end
    results();
  end : main_seq

endmodule : lpsc_top_bench
